// ---- hw/ext_mem_regs.svh ----
/*
 * Register offsets, field positions, reset values and fixed counts of the
 * external data memory bus block. Assumes one 8-bit register port.
 */
`ifndef EXT_MEM_REGS_SVH
`define EXT_MEM_REGS_SVH

`define EXT_REG_CONFIG       2'h0
`define EXT_REG_PAGE         2'h1
`define EXT_REG_TIMING       2'h2
`define EXT_REG_STATUS       2'h3

`define EXT_CFG_MUX_BIT      4
`define EXT_CFG_MODE_HI      3
`define EXT_CFG_MODE_LO      2
`define EXT_CFG_ALE_HI       1
`define EXT_CFG_ALE_LO       0
`define EXT_TC_SETUP_HI      7
`define EXT_TC_SETUP_LO      6
`define EXT_TC_WIDTH_HI      5
`define EXT_TC_WIDTH_LO      2
`define EXT_TC_HOLD_HI       1
`define EXT_TC_HOLD_LO       0
`define EXT_ST_BUSY_BIT      0
`define EXT_ST_OFFCHIP_BIT   1

`define EXT_CONFIG_RESET     8'h00
`define EXT_PAGE_RESET       8'h00
`define EXT_TIMING_RESET     8'hFF

`define EXT_MODE_INTERNAL    2'h0
`define EXT_MODE_SPLIT_NOBANK 2'h1
`define EXT_MODE_SPLIT_BANK  2'h2
`define EXT_MODE_EXTERNAL    2'h3

`define EXT_XRAM_BOUNDARY    16'h1000
`define EXT_XRAM_WORDS       4096
`define EXT_XRAM_ABITS       12

`endif

// ---- hw/ext_mem_pkg.sv ----
/*
 * Types of the external data memory bus block.
 * Assumes ext_mem_regs.svh for numeric constants.
 */
package ext_mem_pkg;

    typedef enum logic [3:0] {
        S_IDLE,
        S_INT,
        S_ADDR,
        S_ALE_H,
        S_ALE_L,
        S_LAUNCH,
        S_SETUP,
        S_STROBE,
        S_HOLD,
        S_TAIL,
        S_DONE
    } state_t;

endpackage

// ---- hw/ext_mem_phase_timer.sv ----
/*
 * Phase length counter: loads a cycle count minus one, counts down,
 * flags the last cycle of the phase. Assumes one clock, async reset.
 */
`timescale 1ns/1ps
module ext_mem_phase_timer
(
    // clock and reset
    input  wire logic       clock_i,
    input  wire logic       rst_i,
    // control
    input  wire logic       load_i,
    input  wire logic [3:0] value_i,
    // status
    output logic            last_o
);
    logic [3:0] count_reg;

    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
            count_reg <= 4'h0;
        else if (load_i)
            count_reg <= value_i;
        else if (count_reg != 4'h0)
            count_reg <= count_reg - 4'h1;
    end

    assign last_o = (count_reg == 4'h0);
endmodule

// ---- hw/external_memory_bus_modes.sv ----
/*
 * External data memory bus: routes external moves to on-chip XRAM or to an
 * off-chip parallel memory, shared or separate address/data lines, with
 * programmable cycle timing. Assumes the core holds a move request for one
 * cycle and waits for done; pins are sampled synchronously.
 */
`timescale 1ns/1ps
`include "ext_mem_regs.svh"
module external_memory_bus_modes
(
    // clock and reset
    input  wire logic        clock_i,
    input  wire logic        rst_i,
    // register port
    input  wire logic [1:0]  reg_addr_i,
    input  wire logic [7:0]  reg_wdata_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    output logic      [7:0]  reg_rdata_o,
    // external move request from the core
    input  wire logic        move_req_i,
    input  wire logic        move_write_i,
    input  wire logic        move_wide_i,
    input  wire logic [15:0] data_pointer_i,
    input  wire logic [7:0]  indirect_register_i,
    input  wire logic [7:0]  move_wdata_i,
    output logic             move_busy_o,
    output logic             move_done_o,
    output logic      [7:0]  move_rdata_o,
    // upper address lines
    output logic      [7:0]  addr_hi_o,
    output logic             addr_hi_oe_o,
    // lower address lines, separate mode only
    output logic      [7:0]  addr_lo_o,
    output logic             addr_lo_oe_o,
    // data lines, shared with low address in multiplexed mode
    input  wire logic [7:0]  data_i,
    output logic      [7:0]  data_o,
    output logic             data_oe_o,
    // strobes
    output logic             latch_strobe_o,
    output logic             read_n_o,
    output logic             write_n_o
);
    logic [7:0]  config_reg;
    logic [7:0]  page_reg;
    logic [7:0]  timing_reg;
    logic [7:0]  rdata_reg;
    logic [7:0]  mem_rdata_reg;
    logic [7:0]  acc_wdata_reg;
    logic [15:0] acc_addr_reg;
    logic        acc_write_reg;
    logic        acc_hi_drive_reg;
    logic        acc_mux_reg;
    logic [7:0]  acc_timing_reg;
    logic [1:0]  acc_ale_reg;
    logic        last_offchip_reg;
    logic [7:0]  addr_hi_reg;
    logic [7:0]  addr_lo_reg;
    logic [7:0]  data_out_reg;

    ext_mem_pkg::state_t state_reg;
    ext_mem_pkg::state_t state_next;

    logic [1:0]  mode;
    logic [15:0] eff_addr;
    logic        go_offchip;
    logic        hi_drive;
    logic        move_take;
    logic        phase_last;
    logic        phase_load;
    logic [3:0]  phase_value;
    logic [1:0]  setup_cyc;
    logic [3:0]  width_m1;
    logic [1:0]  hold_cyc;

    logic [7:0]  xram_mem [0:`EXT_XRAM_WORDS-1];

    assign mode      = config_reg[`EXT_CFG_MODE_HI:`EXT_CFG_MODE_LO];
    assign move_take = move_req_i && (state_reg == ext_mem_pkg::S_IDLE);

    assign eff_addr = move_wide_i ? data_pointer_i : {page_reg, indirect_register_i};

    // target and upper-line drive per memory mode
    always_comb
    begin
        go_offchip = 1'b0;
        hi_drive   = 1'b0;
        case (mode)
            `EXT_MODE_INTERNAL:
            begin
                go_offchip = 1'b0;
                hi_drive   = 1'b0;
            end
            `EXT_MODE_SPLIT_NOBANK:
            begin
                go_offchip = (eff_addr >= `EXT_XRAM_BOUNDARY);
                hi_drive   = move_wide_i;
            end
            `EXT_MODE_SPLIT_BANK:
            begin
                go_offchip = (eff_addr >= `EXT_XRAM_BOUNDARY);
                hi_drive   = 1'b1;
            end
            `EXT_MODE_EXTERNAL:
            begin
                go_offchip = 1'b1;
                hi_drive   = move_wide_i;
            end
            default:
            begin
                go_offchip = 1'b0;
                hi_drive   = 1'b0;
            end
        endcase
    end

    // register writes
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            config_reg <= `EXT_CONFIG_RESET;
            page_reg   <= `EXT_PAGE_RESET;
            timing_reg <= `EXT_TIMING_RESET;
        end
        else if (reg_wr_i)
        begin
            case (reg_addr_i)
                `EXT_REG_CONFIG: config_reg <= {3'h0, reg_wdata_i[4:0]};
                `EXT_REG_PAGE:   page_reg   <= reg_wdata_i;
                `EXT_REG_TIMING: timing_reg <= reg_wdata_i;
                default:         config_reg <= config_reg;
            endcase
        end
    end

    // register reads, data one cycle after the strobe
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
            rdata_reg <= 8'h00;
        else if (reg_rd_i)
        begin
            case (reg_addr_i)
                `EXT_REG_CONFIG: rdata_reg <= config_reg;
                `EXT_REG_PAGE:   rdata_reg <= page_reg;
                `EXT_REG_TIMING: rdata_reg <= timing_reg;
                `EXT_REG_STATUS: rdata_reg <= {6'h00, last_offchip_reg, move_busy_o};
                default:         rdata_reg <= 8'h00;
            endcase
        end
        else
            rdata_reg <= 8'h00;
    end

    assign reg_rdata_o = rdata_reg;

    // snapshot of the access, timing frozen for its whole length
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            acc_addr_reg     <= 16'h0000;
            acc_wdata_reg    <= 8'h00;
            acc_write_reg    <= 1'b0;
            acc_hi_drive_reg <= 1'b0;
            acc_mux_reg      <= 1'b0;
            acc_timing_reg   <= `EXT_TIMING_RESET;
            acc_ale_reg      <= 2'h0;
            last_offchip_reg <= 1'b0;
        end
        else if (move_take)
        begin
            acc_addr_reg     <= eff_addr;
            acc_wdata_reg    <= move_wdata_i;
            acc_write_reg    <= move_write_i;
            acc_hi_drive_reg <= hi_drive;
            // shared lines when the select bit is clear
            acc_mux_reg      <= ~config_reg[`EXT_CFG_MUX_BIT];
            acc_timing_reg   <= timing_reg;
            acc_ale_reg      <= config_reg[`EXT_CFG_ALE_HI:`EXT_CFG_ALE_LO];
            last_offchip_reg <= go_offchip;
        end
    end

    assign setup_cyc = acc_timing_reg[`EXT_TC_SETUP_HI:`EXT_TC_SETUP_LO];
    assign width_m1  = acc_timing_reg[`EXT_TC_WIDTH_HI:`EXT_TC_WIDTH_LO];
    assign hold_cyc  = acc_timing_reg[`EXT_TC_HOLD_HI:`EXT_TC_HOLD_LO];

    // four fixed cycles: addr, launch, tail, done
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            ext_mem_pkg::S_IDLE:
            begin
                if (move_take)
                    state_next = go_offchip ? ext_mem_pkg::S_ADDR : ext_mem_pkg::S_INT;
            end
            ext_mem_pkg::S_INT:
                state_next = ext_mem_pkg::S_IDLE;
            ext_mem_pkg::S_ADDR:
            begin
                // latch strobe phases only when shared
                if (acc_mux_reg)
                    state_next = ext_mem_pkg::S_ALE_H;
                else
                    state_next = ext_mem_pkg::S_LAUNCH;
            end
            ext_mem_pkg::S_ALE_H:
            begin
                if (phase_last)
                    state_next = ext_mem_pkg::S_ALE_L;
            end
            ext_mem_pkg::S_ALE_L:
            begin
                if (phase_last)
                    state_next = ext_mem_pkg::S_LAUNCH;
            end
            ext_mem_pkg::S_LAUNCH:
                state_next = (setup_cyc != 2'h0) ? ext_mem_pkg::S_SETUP : ext_mem_pkg::S_STROBE;
            ext_mem_pkg::S_SETUP:
            begin
                if (phase_last)
                    state_next = ext_mem_pkg::S_STROBE;
            end
            ext_mem_pkg::S_STROBE:
            begin
                if (phase_last)
                    state_next = (hold_cyc != 2'h0) ? ext_mem_pkg::S_HOLD : ext_mem_pkg::S_TAIL;
            end
            ext_mem_pkg::S_HOLD:
            begin
                if (phase_last)
                    state_next = ext_mem_pkg::S_TAIL;
            end
            ext_mem_pkg::S_TAIL:
                state_next = ext_mem_pkg::S_DONE;
            ext_mem_pkg::S_DONE:
                state_next = ext_mem_pkg::S_IDLE;
            default:
                state_next = ext_mem_pkg::S_IDLE;
        endcase
    end

    // phase counter load on each state change
    always_comb
    begin
        phase_load  = (state_next != state_reg);
        phase_value = 4'h0;
        case (state_next)
            ext_mem_pkg::S_ALE_H: phase_value = {2'h0, acc_ale_reg};
            ext_mem_pkg::S_ALE_L: phase_value = {2'h0, acc_ale_reg};
            ext_mem_pkg::S_SETUP: phase_value = {2'h0, setup_cyc - 2'h1};
            ext_mem_pkg::S_STROBE: phase_value = width_m1;
            ext_mem_pkg::S_HOLD:  phase_value = {2'h0, hold_cyc - 2'h1};
            default:              phase_value = 4'h0;
        endcase
    end

    ext_mem_phase_timer phase_timer
    (
        .clock_i (clock_i),
        .rst_i   (rst_i),
        .load_i  (phase_load),
        .value_i (phase_value),
        .last_o  (phase_last)
    );

    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
            state_reg <= ext_mem_pkg::S_IDLE;
        else
            state_reg <= state_next;
    end

    // on-chip array, address wraps at 4 kB
    always_ff @(posedge clock_i)
    begin
        if (state_reg == ext_mem_pkg::S_INT && acc_write_reg)
            xram_mem[acc_addr_reg[`EXT_XRAM_ABITS-1:0]] <= acc_wdata_reg;
    end

    // read data: on-chip array or data lines at the strobe's last cycle
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
            mem_rdata_reg <= 8'h00;
        else if (state_reg == ext_mem_pkg::S_INT && !acc_write_reg)
            mem_rdata_reg <= xram_mem[acc_addr_reg[`EXT_XRAM_ABITS-1:0]];
        else if (state_reg == ext_mem_pkg::S_STROBE && phase_last && !acc_write_reg)
            mem_rdata_reg <= data_i;
    end

    assign move_rdata_o = mem_rdata_reg;
    assign move_busy_o  = (state_reg != ext_mem_pkg::S_IDLE);
    assign move_done_o  = (state_reg == ext_mem_pkg::S_INT) || (state_reg == ext_mem_pkg::S_DONE);

    // pin values from flops
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            addr_hi_reg  <= 8'h00;
            addr_lo_reg  <= 8'h00;
            data_out_reg <= 8'h00;
        end
        else if (state_next == ext_mem_pkg::S_ADDR)
        begin
            // upper byte from the live effective address, on the same edge as the snapshot
            addr_hi_reg  <= eff_addr[15:8];
            addr_lo_reg  <= eff_addr[7:0];
            // low address byte on shared lines first
            data_out_reg <= (~config_reg[`EXT_CFG_MUX_BIT]) ? eff_addr[7:0] : move_wdata_i;
        end
        else if (state_next == ext_mem_pkg::S_LAUNCH)
            // shared lines switch to data after the latch closes
            data_out_reg <= acc_wdata_reg;
    end

    assign addr_hi_o      = addr_hi_reg;
    assign addr_lo_o      = addr_lo_reg;
    assign data_o         = data_out_reg;

    // off-chip bus drive windows
    always_comb
    begin
        addr_hi_oe_o   = 1'b0;
        addr_lo_oe_o   = 1'b0;
        data_oe_o      = 1'b0;
        latch_strobe_o = 1'b0;
        read_n_o       = 1'b1;
        write_n_o      = 1'b1;
        case (state_reg)
            ext_mem_pkg::S_IDLE, ext_mem_pkg::S_INT:
            begin
                addr_hi_oe_o = 1'b0;
            end
            default:
            begin
                addr_hi_oe_o = acc_hi_drive_reg;
                addr_lo_oe_o = ~acc_mux_reg;
                // latch strobe high during first phase
                latch_strobe_o = (state_reg == ext_mem_pkg::S_ALE_H);
                if (state_reg == ext_mem_pkg::S_ADDR || state_reg == ext_mem_pkg::S_ALE_H
                    || state_reg == ext_mem_pkg::S_ALE_L)
                    data_oe_o = acc_mux_reg;
                else if (state_reg != ext_mem_pkg::S_DONE)
                    data_oe_o = acc_write_reg;
                read_n_o  = ~((state_reg == ext_mem_pkg::S_STROBE) && !acc_write_reg);
                write_n_o = ~((state_reg == ext_mem_pkg::S_STROBE) && acc_write_reg);
            end
        endcase
    end
endmodule

// ---- bench/ext_sram_model.sv ----
/*
 * Off-chip byte memory with the board address latch in front of it.
 * Assumes the bench tells it which bus select is in force.
 */
`timescale 1ns/1ps
module ext_sram_model
(
    // clock and bus select
    input  wire logic        clock_i,
    input  wire logic        sep_i,
    // pins of the block
    input  wire logic [7:0]  addr_hi_i,
    input  wire logic        addr_hi_oe_i,
    input  wire logic [7:0]  addr_lo_i,
    input  wire logic        addr_lo_oe_i,
    input  wire logic [7:0]  data_i,
    input  wire logic        data_oe_i,
    input  wire logic        latch_strobe_i,
    input  wire logic        read_n_i,
    input  wire logic        write_n_i,
    // answer and observations
    output logic      [7:0]  data_o,
    output logic      [15:0] seen_addr_o,
    output logic             seen_hi_oe_o,
    output logic      [15:0] strobe_cnt_o
);
    logic [7:0]  mem [0:65535];
    logic [7:0]  latch_q;
    logic [7:0]  last;
    logic [15:0] addr;
    logic        in_strobe;
    initial
    begin
        last = 8'h00;
        in_strobe = 1'h0;
        strobe_cnt_o = 16'h0000;
    end
    // latch follows the shared lines while the strobe is high
    always @(posedge clock_i)
        if (latch_strobe_i)
            latch_q <= data_oe_i ? data_i : 8'hFF;
    // released lines float to the pull-up level
    assign addr = {addr_hi_oe_i ? addr_hi_i : 8'hFF, sep_i ? (addr_lo_oe_i ? addr_lo_i : 8'hFF) : latch_q};
    // idle data lines toggle so a late sample cannot pass
    assign data_o = !read_n_i ? mem[addr] : ~last;
    always @(posedge clock_i)
    begin
        last <= data_o;
        in_strobe <= !read_n_i || !write_n_i;
        if (!write_n_i)
            mem[addr] <= data_oe_i ? data_i : 8'hFF;
        if ((!read_n_i || !write_n_i) && !in_strobe)
        begin
            strobe_cnt_o <= strobe_cnt_o + 16'h0001;
            seen_addr_o <= addr;
            seen_hi_oe_o <= addr_hi_oe_i;
        end
    end
endmodule

// ---- bench/ext_mem_checker_properties.sv ----
/*
 * Pin and handshake properties of the external memory bus.
 * Assumes it is bound into external_memory_bus_modes.
 */
`timescale 1ns/1ps
module ext_mem_checker
(
    input wire logic       clock_i,
    input wire logic       rst_i,
    input wire logic       move_req_i,
    input wire logic       move_busy_o,
    input wire logic       move_done_o,
    input wire logic [7:0] data_o,
    input wire logic       data_oe_o,
    input wire logic       latch_strobe_o,
    input wire logic       read_n_o,
    input wire logic       write_n_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (rst_i);
    sequence seq_take;
        move_req_i && !move_busy_o;
    endsequence
    sequence seq_strobe_end;
        (!read_n_o || !write_n_o) ##1 (read_n_o && write_n_o);
    endsequence
    sequence seq_latch_fall;
        latch_strobe_o ##1 !latch_strobe_o;
    endsequence
    a_strobe_exclusive:
        assert property (read_n_o || write_n_o) else $error("both strobes low");
    a_latch_drives_addr:
        assert property (latch_strobe_o |-> data_oe_o && read_n_o && write_n_o) else $error("latch phase wrong");
    a_latch_fall_gap:
        assert property (seq_latch_fall |-> read_n_o && write_n_o) else $error("no latch low phase");
    a_read_released:
        assert property (!read_n_o |-> !data_oe_o) else $error("data driven during read");
    a_write_data_held:
        assert property (!write_n_o && !$past(write_n_o) |-> $stable(data_o) && data_oe_o) else $error("write data moved");
    a_take_sets_busy:
        assert property (seq_take |=> move_busy_o) else $error("busy missing after take");
    a_done_bounded:
        assert property (seq_take |-> ##[1:34] move_done_o) else $error("access too long");
    a_done_single:
        assert property (move_done_o |=> !move_done_o) else $error("done longer than one cycle");
    a_strobe_in_access:
        assert property (!read_n_o || !write_n_o |-> move_busy_o) else $error("strobe outside access");
    a_strobe_to_done:
        assert property (seq_strobe_end |-> ##[1:4] move_done_o) else $error("hold too long");
endmodule
bind external_memory_bus_modes ext_mem_checker u_chk (.clock_i(clock_i), .rst_i(rst_i), .move_req_i(move_req_i),
    .move_busy_o(move_busy_o), .move_done_o(move_done_o), .data_o(data_o), .data_oe_o(data_oe_o),
    .latch_strobe_o(latch_strobe_o), .read_n_o(read_n_o), .write_n_o(write_n_o));

// ---- bench/tb_top.sv ----
/*
 * Random and corner moves over both bus selects and all memory modes.
 * Assumes the sram model answers on the pins.
 */
`timescale 1ns/1ps
module tb_top;
    logic        clock_i, rst_i, reg_wr_i, reg_rd_i, move_req_i, move_write_i, move_wide_i;
    logic        move_busy_o, move_done_o, addr_hi_oe_o, addr_lo_oe_o, data_oe_o;
    logic        latch_strobe_o, read_n_o, write_n_o, sep, seen_hi_oe, wide, off, hi_on;
    logic [1:0]  reg_addr_i, ale;
    logic [7:0]  reg_wdata_i, reg_rdata_o, indirect_register_i, move_wdata_i, move_rdata_o;
    logic [7:0]  addr_hi_o, addr_lo_o, data_i, data_o, v, tc, page, ind, wd;
    logic [15:0] data_pointer_i, seen_addr, strobe_cnt, dp, ea, c0;
    logic [31:0] seed, r;
    int          fails, tests_run, n;
    external_memory_bus_modes uut (.*);
    ext_sram_model model (.clock_i(clock_i), .sep_i(sep), .addr_hi_i(addr_hi_o), .addr_hi_oe_i(addr_hi_oe_o),
        .addr_lo_i(addr_lo_o), .addr_lo_oe_i(addr_lo_oe_o), .data_i(data_o), .data_oe_i(data_oe_o),
        .latch_strobe_i(latch_strobe_o), .read_n_i(read_n_o), .write_n_i(write_n_o), .data_o(data_i),
        .seen_addr_o(seen_addr), .seen_hi_oe_o(seen_hi_oe), .strobe_cnt_o(strobe_cnt));
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic int cycles(logic [7:0] t, logic [1:0] a, logic s, logic o);
        return o ? 5 + t[7:6] + t[5:2] + t[1:0] + (s ? 0 : 2 * (a + 1)) : 1;
    endfunction
    task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            fails++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic reg_wr(logic [1:0] a, logic [7:0] d);
        @(posedge clock_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'h1;
        @(posedge clock_i);
        reg_wr_i <= 1'h0;
    endtask
    task automatic reg_rd(logic [1:0] a);
        @(posedge clock_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'h1;
        @(posedge clock_i);
        reg_rd_i <= 1'h0;
        #1 v = reg_rdata_o;
    endtask
    task automatic move(logic w, logic [15:0] p, logic [7:0] d);
        @(posedge clock_i);
        move_req_i <= 1'h1;
        move_write_i <= w;
        move_wide_i <= wide;
        data_pointer_i <= p;
        indirect_register_i <= ind;
        move_wdata_i <= d;
        @(posedge clock_i);
        move_req_i <= 1'h0;
        #1 n = 1;
        while (move_done_o !== 1'h1 && n < 60)
        begin
            @(posedge clock_i);
            #1 n++;
        end
        // on-chip read data land on the edge that ends the done cycle
        @(posedge clock_i);
        #1 v = move_rdata_o;
    endtask
    task automatic tally_and_finish();
        if (fails == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial
    begin
        clock_i = 1'h0;
        forever #10 clock_i = ~clock_i;
    end
    initial
    begin
        repeat (20000) @(posedge clock_i);
        fails++;
        tally_and_finish();
    end
    initial
    begin
        {reg_wr_i, reg_rd_i, move_req_i, move_write_i, move_wide_i, wide, sep} = 7'h00;
        {reg_addr_i, reg_wdata_i, data_pointer_i, indirect_register_i, move_wdata_i, ind} = 50'h0;
        seed = 32'h00000022;
        fails = 0;
        tests_run = 0;
        rst_i = 1'h1;
        repeat (12) @(posedge clock_i);
        rst_i <= 1'h0;
        reg_rd(2'h2);
        check("timing reset", v, 8'hFF);
        reg_wr(2'h0, 8'hFF);
        reg_rd(2'h0);
        check("config readback", v, 8'h1F);
        for (int s = 0; s < 2; s++)
            for (int m = 0; m < 4; m++)
            begin
                r = rnd();
                ale = r[1:0];
                sep <= s[0];
                reg_wr(2'h0, {3'h0, s[0], m[1:0], ale});
                for (int k = 0; k < 6; k++)
                begin
                    r = rnd();
                    tc = k == 0 ? 8'hFF : k == 1 ? 8'h00 : r[7:0];
                    wide = r[8];
                    page = r[9] ? {4'h0, r[13:10]} : r[23:16];
                    dp = r[9] ? {4'h0, r[31:20]} : r[31:16];
                    r = rnd();
                    ind = r[7:0];
                    wd = r[15:8];
                    reg_wr(2'h2, tc);
                    reg_wr(2'h1, page);
                    ea = wide ? dp : {page, ind};
                    off = m == 3 || (m != 0 && ea >= 16'h1000);
                    hi_on = off && (wide || m == 2);
                    c0 = strobe_cnt;
                    move(1'h1, dp, wd);
                    check("access cycles", n, cycles(tc, ale, s[0], off));
                    check("strobe count", strobe_cnt - c0, off);
                    if (off)
                        check("address", seen_addr, {hi_on ? ea[15:8] : 8'hFF, ea[7:0]});
                    if (off)
                        check("upper driven", seen_hi_oe, hi_on);
                    reg_rd(2'h3);
                    check("offchip flag", v[1], off);
                    move(1'h0, dp, 8'h00);
                    check("read data", v, wd);
                end
            end
        wide = 1'h1;
        reg_wr(2'h0, 8'h10);
        move(1'h1, 16'h2ABC, 8'h5A);
        move(1'h0, 16'h0ABC, 8'h00);
        check("xram wrap", v, 8'h5A);
        reg_wr(2'h0, 8'h1C);
        move(1'h1, 16'h0ABC, 8'hA5);
        move(1'h0, 16'h0ABC, 8'h00);
        check("external low", v, 8'hA5);
        reg_wr(2'h0, 8'h10);
        move(1'h0, 16'h0ABC, 8'h00);
        check("xram hidden", v, 8'h5A);
        tally_and_finish();
    end
endmodule
